// ===== hw/blfc_regs.svh
`ifndef BLFC_REGS_SVH
`define BLFC_REGS_SVH
// ****************************************
// Register offsets
// ****************************************
`define BLFC_OFS_CTRL 8'h03
`define BLFC_OFS_PRI 8'h04
`define BLFC_OFS_SEC 8'h05
`define BLFC_OFS_GPIO 8'h06
`define BLFC_OFS_PWMSEL 8'h2B
// ****************************************
// Field positions
// ****************************************
`define BLFC_BIT_EN_SEC 0
`define BLFC_BIT_EN_PRI 1
`define BLFC_BIT_COMB 2
`define BLFC_BIT_FADE_EN 3
`define BLFC_BIT_FADE_SEL 4
`define BLFC_BIT_SLOPE 5
`define BLFC_BIT_PWM_PIN 4
`define BLFC_BIT_PWM_PRI 0
`define BLFC_BIT_PWM_SEC 1
// ****************************************
// Reset values and timing
// ****************************************
`define BLFC_RST_BYTE 8'h00
`define BLFC_CLK_HZ 125000000
`define BLFC_FULL_SLOW_MS 1300
`define BLFC_FULL_FAST_MS 650
`define BLFC_STEPS 255
// Step interval in cycles, rounded down so a fade never runs long.
`define BLFC_STEP_SLOW_CYC \
   ((`BLFC_CLK_HZ / 1000 * `BLFC_FULL_SLOW_MS) / `BLFC_STEPS)
`define BLFC_STEP_FAST_CYC \
   ((`BLFC_CLK_HZ / 1000 * `BLFC_FULL_FAST_MS) / `BLFC_STEPS)
`endif

// ===== hw/blfc_pkg.sv
`default_nettype none
package blfc_pkg;
   typedef struct packed {
      logic slope;
      logic fade_sel;
      logic fade_en;
      logic combined_display;
      logic en_pri;
      logic en_sec;
   } blfc_ctrl_t;
   typedef struct packed {
      logic we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } blfc_wr_t;
endpackage
`default_nettype wire

// ===== hw/blfc_core.sv
// Behaviour
// - Each string sinks 0.1 mA per code step.
// - Primary code at 04H, secondary at 05H.
// - Combined bit makes both follow primary code.
// - Offset 2BH bits enable PWM gating per string.
// - PWM pin used only while pin-enable set.
// - PWM high conducts, low turns string off.
// - Fading happens only while fade-enable is set.
// - Full-scale fade 1.3 s, or 0.65 s fast.
// - Fade-select picks primary or secondary string.
// - Combined with select zero fades both strings.
// - Smaller changes fade proportionally shorter.
`include "blfc_regs.svh"
`default_nettype none
module blfc_core
   import blfc_pkg::*;
#(
   parameter int unsigned STEP_SLOW = `BLFC_STEP_SLOW_CYC,
   parameter int unsigned STEP_FAST = `BLFC_STEP_FAST_CYC
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire blfc_wr_t wr,
   input wire logic [7:0] rd_addr,
   output logic [7:0] rd_data,
   input wire logic pwm_pin,
   output logic [7:0] pri_code,
   output logic [7:0] sec_code,
   output logic fade_busy
);
   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] ctrl_q, pri_q, sec_q, gpio_q, pwmsel_q;
   logic [7:0] pri_eff_q, sec_eff_q;
   logic [23:0] tick_q;
   logic pwm_m_q, pwm_s_q;
   blfc_ctrl_t ctrl;
   assign ctrl = blfc_ctrl_t'(ctrl_q[5:0]);

   wire wr_ctrl = wr.we && wr.addr == `BLFC_OFS_CTRL;
   wire wr_pri = wr.we && wr.addr == `BLFC_OFS_PRI;
   wire wr_sec = wr.we && wr.addr == `BLFC_OFS_SEC;
   wire wr_gpio = wr.we && wr.addr == `BLFC_OFS_GPIO;
   wire wr_pwm = wr.we && wr.addr == `BLFC_OFS_PWMSEL;

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ctrl_q <= `BLFC_RST_BYTE;
         pri_q <= `BLFC_RST_BYTE;
         sec_q <= `BLFC_RST_BYTE;
         gpio_q <= `BLFC_RST_BYTE;
         pwmsel_q <= `BLFC_RST_BYTE;
      end else begin
         if (wr_ctrl) ctrl_q <= {2'h0, wr.wdata[5:0]};
         if (wr_pri) pri_q <= wr.wdata;
         if (wr_sec) sec_q <= wr.wdata;
         if (wr_gpio) gpio_q <= {3'h0, wr.wdata[4], 4'h0};
         if (wr_pwm) pwmsel_q <= {6'h0, wr.wdata[1:0]};
      end
   end

   // ****************************************
   // Register readback
   // ****************************************
   always_comb begin
      case (rd_addr)
         `BLFC_OFS_CTRL: rd_data = ctrl_q;
         `BLFC_OFS_PRI: rd_data = pri_q;
         `BLFC_OFS_SEC: rd_data = sec_q;
         `BLFC_OFS_GPIO: rd_data = gpio_q;
         `BLFC_OFS_PWMSEL: rd_data = pwmsel_q;
         default: rd_data = 8'h00;
      endcase
   end

   // ****************************************
   // Targets and fade routing
   // ****************************************
   wire [7:0] pri_tgt = pri_q;
   wire [7:0] sec_tgt = ctrl.combined_display ? pri_q : sec_q;
   wire fade_pri = ctrl.fade_en && !ctrl.fade_sel;
   // In combined mode the secondary ramps toward the primary code whenever fading is enabled, even with fade-select set.
   wire fade_sec = ctrl.fade_en &&
      (ctrl.fade_sel || ctrl.combined_display);
   wire [23:0] step_len = ctrl.slope ? 24'(STEP_FAST)
                                     : 24'(STEP_SLOW);
   wire tick = tick_q >= step_len - 24'h1;

   function automatic logic [7:0] step_to(input logic [7:0] cur,
                                          input logic [7:0] tgt);
      if (cur < tgt) return cur + 8'h01;
      else if (cur > tgt) return cur - 8'h01;
      else return cur;
   endfunction

   wire busy_any = (fade_pri && pri_eff_q != pri_tgt) ||
                   (fade_sec && sec_eff_q != sec_tgt);

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tick_q <= 24'h0;
         pri_eff_q <= 8'h00;
         sec_eff_q <= 8'h00;
      end else begin
         // Counter restarts while idle so each fade's first step
         // comes a full interval after the write.
         tick_q <= (!busy_any || tick) ? 24'h0 : tick_q + 24'h1;
         if (!fade_pri) pri_eff_q <= pri_tgt;
         else if (tick) pri_eff_q <= step_to(pri_eff_q, pri_tgt);
         if (!fade_sec) sec_eff_q <= sec_tgt;
         else if (tick) sec_eff_q <= step_to(sec_eff_q, sec_tgt);
      end
   end
   assign fade_busy = busy_any;

   // ****************************************
   // External PWM gating
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pwm_m_q <= 1'b0;
         pwm_s_q <= 1'b0;
      end else begin
         pwm_m_q <= pwm_pin;
         pwm_s_q <= pwm_m_q;
      end
   end
   wire pin_en = gpio_q[`BLFC_BIT_PWM_PIN];
   wire gate_pri = pin_en && pwmsel_q[`BLFC_BIT_PWM_PRI] && !pwm_s_q;
   wire gate_sec = pin_en && pwmsel_q[`BLFC_BIT_PWM_SEC] && !pwm_s_q;

   logic [7:0] pri_out_q, sec_out_q;
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pri_out_q <= 8'h00;
         sec_out_q <= 8'h00;
      end else begin
         pri_out_q <= (ctrl.en_pri && !gate_pri) ? pri_eff_q : 8'h00;
         sec_out_q <= (ctrl.en_sec && !gate_sec) ? sec_eff_q : 8'h00;
      end
   end
   assign pri_code = pri_out_q;
   assign sec_code = sec_out_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   AST_PRI_REG: assert property (wr_pri |=> pri_q == $past(wr.wdata))
      else $error("primary code not stored");
   AST_COMB: assert property (ctrl.combined_display && !fade_sec
      |=> sec_eff_q == $past(pri_q))
      else $error("combined mode not following primary");
   AST_PWMREG: assert property (wr_pwm
      |=> pwmsel_q[1:0] == $past(wr.wdata[1:0]))
      else $error("pwm select not stored");
   AST_PINOFF: assert property (!pin_en && ctrl.en_pri
      |=> pri_code == $past(pri_eff_q))
      else $error("pwm gating without pin enable");
   AST_PWMLOW: assert property (gate_pri |=> pri_code == 8'h00)
      else $error("string on while pwm low");
   AST_NOFADE: assert property (!fade_pri |=> pri_eff_q == $past(pri_tgt))
      else $error("primary faded while fade off");
   AST_STEP1: assert property (fade_pri && $changed(pri_eff_q)
      |-> (pri_eff_q - $past(pri_eff_q) == 8'h01) ||
          ($past(pri_eff_q) - pri_eff_q == 8'h01))
      else $error("fade step not one code");
   AST_SLOPE: assert property (tick_q <= step_len)
      else $error("step counter overran interval");
   AST_SECSEL: assert property (ctrl.fade_en && ctrl.fade_sel
      |-> fade_sec && !fade_pri)
      else $error("fade routed to wrong string");
   AST_BOTH: assert property (ctrl.fade_en && ctrl.combined_display
      && !ctrl.fade_sel |-> fade_pri && fade_sec)
      else $error("combined fade not on both");
   AST_PROP: assert property (tick && busy_any && fade_pri
      && pri_eff_q != pri_tgt |=> pri_eff_q != $past(pri_eff_q))
      else $error("fade stalled on tick");
   COV_FADE: cover property (fade_pri && tick && busy_any);
   COV_COMB: cover property (ctrl.combined_display && fade_sec);
   COV_PWM: cover property (gate_pri ##1 !gate_pri);
endmodule
`default_nettype wire

// ===== verification/blfc_led_model.sv
`default_nettype none
// ****
// White LED string seen as a current sink
// ****
module blfc_led_model (
   input wire logic [7:0] code,
   output logic [14:0] i_ua
);
   timeunit 1ns;
   timeprecision 1ps;
   // Typical sink current in microamps, with no saturation modelled.
   assign i_ua = 15'(code) * 15'h64;
endmodule
`default_nettype wire

// ===== verification/backlight_current_fade_control_tb.sv
`default_nettype none
module backlight_current_fade_control_tb import blfc_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic pwm_pin = 1'b0;
   blfc_wr_t wr = '0;
   logic [7:0] rd_addr = 8'h00;
   logic [7:0] rd_data, pri_code, sec_code;
   logic fade_busy;
   logic [14:0] pri_ua;
   int mismatches = 0;
   int checks_done = 0;
   int n;
   logic [7:0] ofs [6] = '{8'h03, 8'h04, 8'h05, 8'h06, 8'h2B, 8'h10};
   always #4 clk = ~clk;
   blfc_core #(.STEP_SLOW(4), .STEP_FAST(2)) i_dut (.clk(clk),
      .rst_b(rst_b), .wr(wr), .rd_addr(rd_addr), .rd_data(rd_data),
      .pwm_pin(pwm_pin), .pri_code(pri_code), .sec_code(sec_code),
      .fade_busy(fade_busy));
   blfc_led_model i_led (.code(pri_code), .i_ua(pri_ua));
   // ****
   // Access and compare tasks
   // ****
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = '{we: 1'b1, addr: a, wdata: d};
      @(negedge clk);
      wr.we = 1'b0;
   endtask
   task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd_addr = a;
      #1 chk(16'(rd_data), 16'(exp));
   endtask
   // Waits out the write, decode and output stages before looking.
   task automatic settle;
      repeat (6) @(negedge clk);
   endtask
   // Busy is counted from one cycle after the write, so the window is wide.
   task automatic fade(input logic [7:0] a, d, input int lo, hi);
      wreg(a, d);
      @(negedge clk);
      n = 1;
      while (fade_busy !== 1'b0 && n < 3000) begin
         @(negedge clk);
         n++;
      end
      chk(16'(n >= lo && n <= hi), 16'h1);
      // The code output is registered one cycle behind the ramp.
      repeat (2) @(negedge clk);
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      summarize();
   end
   initial begin
      repeat (12) @(negedge clk);
      rst_b = 1'b1;
      foreach (ofs[i]) rreg(ofs[i], 8'h00);
      $display("reset values done");
      wreg(8'h03, 8'h03);
      wreg(8'h04, 8'hFF);
      wreg(8'h05, 8'h25);
      settle();
      chk(16'(pri_code), 16'hFF);
      chk(16'(sec_code), 16'h25);
      chk(16'(pri_ua), 16'h639C);
      rreg(8'h05, 8'h25);
      wreg(8'h03, 8'h07);
      settle();
      chk(16'(sec_code), 16'hFF);
      wreg(8'h03, 8'h03);
      $display("codes done");
      wreg(8'h2B, 8'h01);
      wreg(8'h06, 8'h10);
      settle();
      chk(16'(pri_code), 16'h00);
      chk(16'(sec_code), 16'h25);
      pwm_pin = 1'b1;
      settle();
      chk(16'(pri_code), 16'hFF);
      pwm_pin = 1'b0;
      wreg(8'h06, 8'h00);
      settle();
      chk(16'(pri_code), 16'hFF);
      wreg(8'h2B, 8'h00);
      $display("pwm done");
      wreg(8'h03, 8'h0B);
      fade(8'h04, 8'h7F, 505, 525);
      chk(16'(pri_code), 16'h7F);
      wreg(8'h03, 8'h2B);
      fade(8'h04, 8'hFF, 250, 266);
      wreg(8'h03, 8'h1B);
      wreg(8'h04, 8'h10);
      settle();
      chk(16'(pri_code), 16'h10);
      fade(8'h05, 8'h05, 120, 136);
      chk(16'(sec_code), 16'h05);
      wreg(8'h03, 8'h0F);
      // Let the secondary ramp onto the primary code before the new target.
      repeat (60) @(negedge clk);
      wreg(8'h04, 8'h7F);
      repeat (100) @(negedge clk);
      chk(16'(fade_busy), 16'h1);
      chk(16'(sec_code), 16'(pri_code));
      $display("fade done");
      summarize();
   end
endmodule
`default_nettype wire
